// ---- rtl/ptf_pkg.sv ----
// Constants shared by the transmit timestamp filter configuration block.
package ptf_pkg;
  localparam int PTF_DATA_W = 32;
  localparam int PTF_ADDR_W = 12;
  localparam int PTF_PORT_W = 2;
  localparam int PTF_BANK_W = 3;
  // Register byte offsets, and the bank that holds the port words.
  localparam logic [11:0] PTF_OFF_SELECT = 12'h100;
  localparam logic [11:0] PTF_OFF_CONTROL = 12'h104;
  localparam logic [11:0] PTF_OFF_STATUS = 12'h108;
  localparam logic [11:0] PTF_OFF_TS_CFG = 12'h15C;
  localparam logic [11:0] PTF_OFF_TX_MOD = 12'h164;
  localparam logic [2:0] PTF_PORT_BANK = 3'h2;
  // Bank and port selector fields, and the control enable bit.
  localparam int PTF_SEL_BANK_LSB = 0;
  localparam int PTF_SEL_PORT_LSB = 8;
  localparam int PTF_CTRL_EN_BIT = 0;
  // Timestamp filter configuration fields.
  localparam int PTF_DOM_LSB = 24;
  localparam int PTF_DOM_W = 8;
  localparam int PTF_DOM_EN_BIT = 23;
  localparam int PTF_ALT_BIT = 22;
  localparam int PTF_UDP_BYP_BIT = 21;
  localparam int PTF_FCS_BYP_BIT = 20;
  localparam int PTF_VER_LSB = 16;
  localparam int PTF_VER_W = 4;
  localparam int PTF_TYPE_LSB = 0;
  localparam int PTF_TYPE_W = 16;
  // Message modification fields.
  localparam int PTF_CLR_BIT = 31;
  localparam int PTF_SUPP_BIT = 30;
  localparam int PTF_TA_BIT = 29;
  localparam int PTF_SYNC_BIT = 28;
  localparam int PTF_RSVQ_LSB = 22;
  localparam int PTF_SECS_LSB = 16;
  localparam int PTF_OFF_W = 6;
  localparam int PTF_CF_LSB = 0;
  // Field reset values, and the version value that matches any version.
  localparam logic [7:0] PTF_DOM_RST = 8'h00;
  localparam logic [3:0] PTF_VER_RST = 4'h2;
  localparam logic [3:0] PTF_VER_ANY = 4'h0;
  localparam logic [15:0] PTF_TYPE_RST = 16'h0000;
  localparam logic [5:0] PTF_RSVQ_RST = 6'h10;
  localparam logic [5:0] PTF_SECS_RST = 6'h05;
  localparam logic [15:0] PTF_CF_RST = 16'h000F;
  localparam logic [31:0] PTF_TS_CFG_RST = {PTF_DOM_RST, 4'h0, PTF_VER_RST, PTF_TYPE_RST};
  localparam logic [31:0] PTF_TX_MOD_RST = {4'h0, PTF_RSVQ_RST, PTF_SECS_RST, PTF_CF_RST};
  localparam logic [2:0] PTF_SEL_BANK_RST = 3'h0;
  localparam logic [1:0] PTF_SEL_PORT_RST = 2'h0;
  // Message type codes.
  localparam logic [3:0] PTF_MSG_SYNC = 4'h0;
  localparam logic [3:0] PTF_MSG_PDELAY_RESP = 4'h3;
  // Word index inside one port bank.
  typedef enum logic {PTF_WORD_CFG = 1'b0, PTF_WORD_MOD = 1'b1} ptf_word_t;
endpackage : ptf_pkg

// ---- rtl/ptf_port_regs.sv ----
// Banked per-port configuration words with registered read ports.
`timescale 1ns/1ps
module ptf_port_regs
  import ptf_pkg::*;
#(
  parameter int NUM_PORTS = 3
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Write port.
  input wire logic wr_en,
  input wire logic [ptf_pkg::PTF_PORT_W-1:0] wr_port,
  input wire ptf_pkg::ptf_word_t wr_word,
  input wire logic [ptf_pkg::PTF_DATA_W-1:0] wr_data,
  // Software read port.
  input wire logic [ptf_pkg::PTF_PORT_W-1:0] rd_a_port,
  input wire ptf_pkg::ptf_word_t rd_a_word,
  output logic [ptf_pkg::PTF_DATA_W-1:0] rd_a_data,
  // Transmit path read port.
  input wire logic [ptf_pkg::PTF_PORT_W-1:0] rd_b_port,
  output logic [ptf_pkg::PTF_DATA_W-1:0] rd_b_cfg,
  output logic [ptf_pkg::PTF_DATA_W-1:0] rd_b_mod
);
  logic [PTF_DATA_W-1:0] cfg_mem [NUM_PORTS];
  logic [PTF_DATA_W-1:0] mod_mem [NUM_PORTS];
  logic a_ok;
  logic b_ok;

  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        cfg_mem[p] <= PTF_TS_CFG_RST;
        mod_mem[p] <= PTF_TX_MOD_RST;
      end
      else if (wr_en && (32'(wr_port) == p))
      begin
        if (wr_word == PTF_WORD_CFG)
          cfg_mem[p] <= wr_data;
        else
          mod_mem[p] <= wr_data;
      end
    end
  end

  assign a_ok = 32'(rd_a_port) < NUM_PORTS;
  assign b_ok = 32'(rd_b_port) < NUM_PORTS;

  // Ports beyond the implemented count read as zero.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_a_data <= '0;
      rd_b_cfg <= '0;
      rd_b_mod <= '0;
    end
    else
    begin
      rd_a_data <= !a_ok ? '0 :
                   (rd_a_word == PTF_WORD_CFG) ? cfg_mem[rd_a_port] : mod_mem[rd_a_port];
      rd_b_cfg <= b_ok ? cfg_mem[rd_b_port] : '0;
      rd_b_mod <= b_ok ? mod_mem[rd_b_port] : '0;
    end
  end
endmodule : ptf_port_regs

// ---- rtl/ptf_egress_filter.sv ----
// Combinational egress timestamp decision and modification selection.
`timescale 1ns/1ps
module ptf_egress_filter
  import ptf_pkg::*;
(
  // Configuration words of the frame's port, and the protocol enable.
  input wire logic [ptf_pkg::PTF_DATA_W-1:0] cfg_word,
  input wire logic [ptf_pkg::PTF_DATA_W-1:0] mod_word,
  input wire logic enable,
  // Frame fields.
  input wire logic [3:0] msg_type,
  input wire logic [3:0] version,
  input wire logic [7:0] domain,
  input wire logic alt_master,
  input wire logic udp_ok,
  input wire logic fcs_ok,
  input wire logic from_host,
  input wire logic forwarded,
  // Decisions.
  output logic record,
  output logic cf_modify,
  output logic ta_insert,
  output logic sync_insert,
  output logic clear_reserved
);
  logic type_ok;
  logic ver_ok;
  logic dom_ok;
  logic alt_ok;
  logic sum_ok;
  logic crc_ok;
  logic suppress;

  always_comb
  begin
    type_ok = cfg_word[PTF_TYPE_LSB + 32'(msg_type)];
    ver_ok = (cfg_word[PTF_VER_LSB +: PTF_VER_W] == PTF_VER_ANY) ||
             (cfg_word[PTF_VER_LSB +: PTF_VER_W] == version);
    dom_ok = !cfg_word[PTF_DOM_EN_BIT] || (cfg_word[PTF_DOM_LSB +: PTF_DOM_W] == domain);
    alt_ok = !cfg_word[PTF_ALT_BIT] || !alt_master;
    sum_ok = cfg_word[PTF_UDP_BYP_BIT] || udp_ok;
    crc_ok = cfg_word[PTF_FCS_BYP_BIT] || fcs_ok;
    cf_modify = enable && forwarded && mod_word[PTF_CF_LSB + 32'(msg_type)];
    ta_insert = enable && from_host && mod_word[PTF_TA_BIT] &&
                (msg_type == PTF_MSG_PDELAY_RESP);
    sync_insert = enable && from_host && mod_word[PTF_SYNC_BIT] &&
                  (msg_type == PTF_MSG_SYNC);
    clear_reserved = mod_word[PTF_CLR_BIT] && (cf_modify || ta_insert || sync_insert);
    suppress = mod_word[PTF_SUPP_BIT] && cf_modify;
    record = enable && type_ok && ver_ok && dom_ok && alt_ok && sum_ok && crc_ok &&
             !suppress;
  end
endmodule : ptf_egress_filter

// ---- rtl/ptf_top.sv ----
// APB register bank and transmit decision pipeline for egress timestamp filtering.
`timescale 1ns/1ps
module ptf_top
  import ptf_pkg::*;
#(
  parameter int NUM_PORTS = 3
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [ptf_pkg::PTF_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ptf_pkg::PTF_DATA_W-1:0] pwdata,
  output logic [ptf_pkg::PTF_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Frame descriptor from the transmit path.
  input wire logic tx_frame_valid,
  input wire logic [ptf_pkg::PTF_PORT_W-1:0] tx_port,
  input wire logic [3:0] tx_msg_type,
  input wire logic [3:0] tx_version,
  input wire logic [7:0] tx_domain,
  input wire logic tx_alt_master,
  input wire logic tx_udp_ok,
  input wire logic tx_fcs_ok,
  input wire logic tx_from_host,
  input wire logic tx_forwarded,
  // Decision back to the transmit path.
  output logic protocol_enable,
  output logic dec_valid,
  output logic [ptf_pkg::PTF_PORT_W-1:0] dec_port,
  output logic [3:0] dec_msg_type,
  output logic dec_record,
  output logic dec_cf_modify,
  output logic dec_turnaround_insert,
  output logic dec_sync_insert,
  output logic dec_clear_reserved,
  output logic [5:0] dec_reserved_offset,
  output logic [5:0] dec_seconds_offset
);
  import ptf_pkg::*;

  // Local registers.
  logic [PTF_BANK_W-1:0] bank_sel_reg;
  logic [PTF_PORT_W-1:0] port_sel_reg;
  logic enable_reg;
  logic [15:0] recorded_cnt_reg;
  logic [15:0] withheld_cnt_reg;

  // Bus decode.
  logic hit_select;
  logic hit_control;
  logic hit_status;
  logic hit_cfg;
  logic hit_mod;
  logic port_window;
  logic mapped;
  logic access_wr;
  ptf_word_t bus_word;
  logic [PTF_DATA_W-1:0] mem_rd_data;
  logic [PTF_DATA_W-1:0] sel_word;

  // Transmit pipeline.
  logic s1_valid_reg;
  logic [PTF_PORT_W-1:0] s1_port_reg;
  logic [3:0] s1_type_reg;
  logic [3:0] s1_ver_reg;
  logic [7:0] s1_dom_reg;
  logic s1_alt_reg;
  logic s1_udp_reg;
  logic s1_fcs_reg;
  logic s1_host_reg;
  logic s1_fwd_reg;
  logic [PTF_DATA_W-1:0] port_cfg;
  logic [PTF_DATA_W-1:0] port_mod;
  logic f_record;
  logic f_cf;
  logic f_ta;
  logic f_sync;
  logic f_clear;

  assign hit_select = paddr == PTF_OFF_SELECT;
  assign hit_control = paddr == PTF_OFF_CONTROL;
  assign hit_status = paddr == PTF_OFF_STATUS;
  assign hit_cfg = paddr == PTF_OFF_TS_CFG;
  assign hit_mod = paddr == PTF_OFF_TX_MOD;
  // The port words share their offsets with other banks; outside bank 2 they read zero.
  assign port_window = (bank_sel_reg == PTF_PORT_BANK) &&
                       (32'(port_sel_reg) < NUM_PORTS);
  assign mapped = hit_select || hit_control || hit_status || hit_cfg || hit_mod;
  assign access_wr = psel && penable && pwrite;
  assign bus_word = hit_mod ? PTF_WORD_MOD : PTF_WORD_CFG;

  // Every access completes without wait states.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  assign sel_word = {{(PTF_DATA_W - PTF_SEL_PORT_LSB - PTF_PORT_W){1'b0}}, port_sel_reg,
                     {(PTF_SEL_PORT_LSB - PTF_BANK_W){1'b0}}, bank_sel_reg};

  // Read data is a plain mux of stored words, so every read finishes with no wait state.
  always_comb
  begin
    prdata = '0;
    if (psel && !pwrite)
    begin
      if (hit_select)
        prdata = sel_word;
      else if (hit_control)
        prdata = {{(PTF_DATA_W - 1){1'b0}}, enable_reg};
      else if (hit_status)
        prdata = {withheld_cnt_reg, recorded_cnt_reg};
      else if ((hit_cfg || hit_mod) && port_window)
        prdata = mem_rd_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bank_sel_reg <= PTF_SEL_BANK_RST;
    else if (access_wr && hit_select)
      bank_sel_reg <= pwdata[PTF_SEL_BANK_LSB +: PTF_BANK_W];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_sel_reg <= PTF_SEL_PORT_RST;
    else if (access_wr && hit_select)
      port_sel_reg <= pwdata[PTF_SEL_PORT_LSB +: PTF_PORT_W];
  end

  // The block does not lock the port words while enabled; software keeps that discipline.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable_reg <= 1'b0;
    else if (access_wr && hit_control)
      enable_reg <= pwdata[PTF_CTRL_EN_BIT];
  end

  assign protocol_enable = enable_reg;

  // Bus and transmit path read the words through separate ports, so a read never stalls a frame.
  ptf_port_regs #(
    .NUM_PORTS(NUM_PORTS)
  ) u_port_regs (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(access_wr && (hit_cfg || hit_mod) && port_window),
    .wr_port(port_sel_reg),
    .wr_word(bus_word),
    .wr_data(pwdata),
    .rd_a_port(port_sel_reg),
    .rd_a_word(bus_word),
    .rd_a_data(mem_rd_data),
    .rd_b_port(tx_port),
    .rd_b_cfg(port_cfg),
    .rd_b_mod(port_mod)
  );

  // The descriptor waits one cycle so that its port words arrive from the memory beside it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s1_valid_reg <= 1'b0;
    else
      s1_valid_reg <= tx_frame_valid;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_port_reg <= '0;
      s1_type_reg <= '0;
    end
    else if (tx_frame_valid)
    begin
      s1_port_reg <= tx_port;
      s1_type_reg <= tx_msg_type;
    end
  end

  // Qualifiers are captured only with a descriptor, so idle cycles cannot disturb a decision.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_ver_reg <= '0;
      s1_dom_reg <= '0;
      s1_alt_reg <= 1'b0;
      s1_udp_reg <= 1'b0;
      s1_fcs_reg <= 1'b0;
      s1_host_reg <= 1'b0;
      s1_fwd_reg <= 1'b0;
    end
    else if (tx_frame_valid)
    begin
      s1_ver_reg <= tx_version;
      s1_dom_reg <= tx_domain;
      s1_alt_reg <= tx_alt_master;
      s1_udp_reg <= tx_udp_ok;
      s1_fcs_reg <= tx_fcs_ok;
      s1_host_reg <= tx_from_host;
      s1_fwd_reg <= tx_forwarded;
    end
  end

  // The filter uses the enable of the cycle after the descriptor, not the one before it.
  ptf_egress_filter u_filter (
    .cfg_word(port_cfg),
    .mod_word(port_mod),
    .enable(enable_reg),
    .msg_type(s1_type_reg),
    .version(s1_ver_reg),
    .domain(s1_dom_reg),
    .alt_master(s1_alt_reg),
    .udp_ok(s1_udp_reg),
    .fcs_ok(s1_fcs_reg),
    .from_host(s1_host_reg),
    .forwarded(s1_fwd_reg),
    .record(f_record),
    .cf_modify(f_cf),
    .ta_insert(f_ta),
    .sync_insert(f_sync),
    .clear_reserved(f_clear)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dec_valid <= 1'b0;
    else
      dec_valid <= s1_valid_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dec_port <= '0;
      dec_msg_type <= '0;
    end
    else if (s1_valid_reg)
    begin
      dec_port <= s1_port_reg;
      dec_msg_type <= s1_type_reg;
    end
  end

  // Each decision bit holds until the next descriptor, so the transmit path may read it late.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dec_record <= 1'b0;
    else if (s1_valid_reg)
      dec_record <= f_record;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dec_cf_modify <= 1'b0;
    else if (s1_valid_reg)
      dec_cf_modify <= f_cf;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dec_turnaround_insert <= 1'b0;
    else if (s1_valid_reg)
      dec_turnaround_insert <= f_ta;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dec_sync_insert <= 1'b0;
    else if (s1_valid_reg)
      dec_sync_insert <= f_sync;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dec_clear_reserved <= 1'b0;
    else if (s1_valid_reg)
      dec_clear_reserved <= f_clear;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dec_reserved_offset <= PTF_RSVQ_RST;
    else if (s1_valid_reg)
      dec_reserved_offset <= port_mod[PTF_RSVQ_LSB +: PTF_OFF_W];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dec_seconds_offset <= PTF_SECS_RST;
    else if (s1_valid_reg)
      dec_seconds_offset <= port_mod[PTF_SECS_LSB +: PTF_OFF_W];
  end

  // Counters wrap; software takes differences between two reads.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      recorded_cnt_reg <= 16'h0000;
    else if (s1_valid_reg && f_record)
      recorded_cnt_reg <= recorded_cnt_reg + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      withheld_cnt_reg <= 16'h0000;
    else if (s1_valid_reg && !f_record)
      withheld_cnt_reg <= withheld_cnt_reg + 16'h0001;
  end
endmodule : ptf_top

// ---- dv/ptf_txpath_model.sv ----
// Behavioural transmit path that issues one frame descriptor per request.
`timescale 1ns/1ps
module ptf_txpath_model
  import ptf_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Request from the bench.
  input wire logic go,
  input wire logic [22:0] dsc,
  // Descriptor toward the block: port, type, version, domain, flags.
  output logic tx_frame_valid,
  output logic [22:0] tx_fields
);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_frame_valid <= 1'b0;
      tx_fields <= '0;
    end
    else
    begin
      tx_frame_valid <= go;
      // Fields flip outside a descriptor so a stale value is never mistaken for a live one.
      tx_fields <= go ? dsc : ~tx_fields;
    end
  end
endmodule : ptf_txpath_model

// ---- dv/ptf_checker.sv ----
// Concurrent checks on the ports of the filter configuration block.
`timescale 1ns/1ps
module ptf_checker
  import ptf_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  // Descriptor and decision.
  input wire logic tx_frame_valid,
  input wire logic [1:0] tx_port,
  input wire logic [3:0] tx_msg_type,
  input wire logic protocol_enable,
  input wire logic dec_valid,
  input wire logic [1:0] dec_port,
  input wire logic [3:0] dec_msg_type,
  input wire logic dec_record,
  input wire logic dec_cf_modify,
  input wire logic dec_turnaround_insert,
  input wire logic dec_sync_insert,
  input wire logic dec_clear_reserved
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic mods = dec_cf_modify | dec_turnaround_insert | dec_sync_insert;
  lat_two_a: assert property (tx_frame_valid |-> ##2 dec_valid)
    else $error("decision missing two cycles after descriptor");
  dec_cause_a: assert property (dec_valid |-> $past(tx_frame_valid, 2))
    else $error("decision without descriptor");
  echo_fields_a: assert property (dec_valid |-> dec_port == $past(tx_port, 2)
    && dec_msg_type == $past(tx_msg_type, 2))
    else $error("decision port or type wrong");
  hold_dec_a: assert property (!dec_valid |->
    $stable({dec_record, mods, dec_clear_reserved}))
    else $error("decision changed between decisions");
  en_gate_a: assert property (dec_valid && (dec_record || mods) |->
    $past(protocol_enable))
    else $error("action while protocol disabled");
  clr_cause_a: assert property (dec_clear_reserved |-> mods)
    else $error("reserved clear on unmodified frame");
  ta_type_a: assert property (dec_turnaround_insert |->
    dec_msg_type == PTF_MSG_PDELAY_RESP)
    else $error("turnaround insert on wrong type");
  sync_type_a: assert property (dec_sync_insert |-> dec_msg_type == PTF_MSG_SYNC)
    else $error("sync insert on wrong type");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  rec_c: cover property (dec_valid && dec_record);
  supp_c: cover property (dec_valid && dec_cf_modify && !dec_record);
  err_c: cover property (pslverr);
endmodule : ptf_checker
bind ptf_top ptf_checker u_chk (.pclk, .presetn, .psel, .penable, .pslverr, .tx_frame_valid,
  .tx_port, .tx_msg_type, .protocol_enable, .dec_valid, .dec_port, .dec_msg_type, .dec_record,
  .dec_cf_modify, .dec_turnaround_insert, .dec_sync_insert, .dec_clear_reserved);

// ---- dv/tb_ptf_top.sv ----
// Self-checking bench for the egress timestamp filter configuration block.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_ptf_top;
  import ptf_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [22:0] dsc = '0, tf;
  logic pready, pslverr, pe, tv, pen, dv, drc, dcf, dta, dsy, dcl;
  logic [5:0] dro, dso;
  logic [89:0] r;
  int err_count = 0, n_tests = 0;
  // Row: filter word, modification word, descriptor, expected record/cf/ta/sync/clear.
  logic [89:0] rows [18] = '{
    {32'h00020001, 32'h0405000F, 4'h0, 4'h2, 8'h00, 5'b01100, 5'b10000},
    {32'h00020001, 32'h0405000F, 4'h1, 4'h2, 8'h00, 5'b01100, 5'b00000},
    {32'h00030001, 32'h0405000F, 4'h0, 4'h2, 8'h00, 5'b01100, 5'b00000},
    {32'h00000001, 32'h0405000F, 4'h0, 4'h7, 8'h00, 5'b01100, 5'b10000},
    {32'h05820001, 32'h0405000F, 4'h0, 4'h2, 8'h05, 5'b01100, 5'b10000},
    {32'h05820001, 32'h0405000F, 4'h0, 4'h2, 8'h04, 5'b01100, 5'b00000},
    {32'h05020001, 32'h0405000F, 4'h0, 4'h2, 8'h04, 5'b01100, 5'b10000},
    {32'h00420001, 32'h0405000F, 4'h0, 4'h2, 8'h00, 5'b11100, 5'b00000},
    {32'h00020001, 32'h0405000F, 4'h0, 4'h2, 8'h00, 5'b00100, 5'b00000},
    {32'h00220001, 32'h0405000F, 4'h0, 4'h2, 8'h00, 5'b00100, 5'b10000},
    {32'h00020001, 32'h0405000F, 4'h0, 4'h2, 8'h00, 5'b01000, 5'b00000},
    {32'h00120001, 32'h0405000F, 4'h0, 4'h2, 8'h00, 5'b01000, 5'b10000},
    {32'h00020001, 32'hC405000F, 4'h0, 4'h2, 8'h00, 5'b01101, 5'b01001},
    {32'h00020001, 32'h0405000F, 4'h0, 4'h2, 8'h00, 5'b01101, 5'b11000},
    {32'h00020001, 32'h04050000, 4'h0, 4'h2, 8'h00, 5'b01101, 5'b10000},
    {32'h0002000F, 32'hA4050000, 4'h3, 4'h2, 8'h00, 5'b01110, 5'b10101},
    {32'h00020001, 32'h1A950000, 4'h0, 4'h2, 8'h00, 5'b01110, 5'b10010},
    {32'h00020001, 32'h14050000, 4'h0, 4'h2, 8'h00, 5'b01100, 5'b10000}};
  always #50 pclk = ~pclk;
  ptf_txpath_model u_path (.pclk(pclk), .presetn(presetn), .go(go), .dsc(dsc),
    .tx_frame_valid(tv), .tx_fields(tf));
  ptf_top #(.NUM_PORTS(3)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_frame_valid(tv), .tx_port(tf[22:21]), .tx_msg_type(tf[20:17]),
    .tx_version(tf[16:13]), .tx_domain(tf[12:5]), .tx_alt_master(tf[4]), .tx_udp_ok(tf[3]),
    .tx_fcs_ok(tf[2]), .tx_from_host(tf[1]), .tx_forwarded(tf[0]), .protocol_enable(pen),
    .dec_valid(dv), .dec_port(), .dec_msg_type(), .dec_record(drc), .dec_cf_modify(dcf),
    .dec_turnaround_insert(dta), .dec_sync_insert(dsy), .dec_clear_reserved(dcl),
    .dec_reserved_offset(dro), .dec_seconds_offset(dso));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    pe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // The decision is looked at just after the edge that raises it, while it still stands.
  task automatic send(input logic [22:0] d);
    @(posedge pclk);
    go <= 1'b1;
    dsc <= d;
    @(posedge pclk);
    go <= 1'b0;
    for (int k = 0; k < 8 && dv !== 1'b1; k++)
    begin
      @(posedge pclk);
      #1;
    end
  endtask : send
  task summarize();
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (5000) @(posedge pclk);
    err_count++;
    summarize();
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, PTF_OFF_SELECT, 32'h00000002);
    for (int i = 0; i < 18; i++)
    begin
      r = rows[i];
      // Filter words are only rewritten with the protocol disabled.
      apb(1'b1, PTF_OFF_CONTROL, 32'h00000000);
      apb(1'b1, PTF_OFF_TS_CFG, r[89:58]);
      apb(1'b1, PTF_OFF_TX_MOD, r[57:26]);
      apb(1'b1, PTF_OFF_CONTROL, 32'h00000001);
      send({2'h0, r[25:5]});
      `CHK({dv, drc, dcf, dta, dsy, dcl}, {1'b1, r[4:0]})
      `CHK({dro, dso}, r[53:42])
    end
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    `CHK({pen, dro, dso}, {1'b0, 6'h10, 6'h05})
    apb(1'b1, PTF_OFF_SELECT, 32'h00000002);
    apb(1'b0, PTF_OFF_TS_CFG, 32'h0);
    `CHK(rd, 32'h00020000)
    apb(1'b0, PTF_OFF_TX_MOD, 32'h0);
    `CHK(rd, 32'h0405000F)
    apb(1'b1, PTF_OFF_TS_CFG, 32'h00020001);
    send({2'h0, 4'h0, 4'h2, 8'h00, 5'b01100});
    `CHK({dv, drc}, 2'b10)
    apb(1'b1, PTF_OFF_SELECT, 32'h00000102);
    apb(1'b1, PTF_OFF_TS_CFG, 32'h12345678);
    apb(1'b0, PTF_OFF_TS_CFG, 32'h0);
    `CHK(rd, 32'h12345678)
    apb(1'b0, PTF_OFF_SELECT, 32'h0);
    `CHK(rd, 32'h00000102)
    apb(1'b1, PTF_OFF_CONTROL, 32'h00000001);
    apb(1'b0, PTF_OFF_CONTROL, 32'h0);
    `CHK({pen, rd}, {1'b1, 32'h00000001})
    // One descriptor on two ports: only the port whose words enable type 3 records it.
    send({2'h1, 4'h3, 4'h4, 8'h00, 5'b00000});
    `CHK({dv, drc, dcf, dta, dsy, dcl}, 6'b110000)
    send({2'h0, 4'h3, 4'h4, 8'h00, 5'b00000});
    `CHK({dv, drc}, 2'b10)
    apb(1'b1, PTF_OFF_SELECT, 32'h00000002);
    apb(1'b0, PTF_OFF_TS_CFG, 32'h0);
    `CHK(rd, 32'h00020001)
    apb(1'b1, PTF_OFF_SELECT, 32'h00000003);
    apb(1'b0, PTF_OFF_TS_CFG, 32'h0);
    `CHK({pe, rd}, 33'h0)
    apb(1'b0, 12'h200, 32'h0);
    `CHK({pe, rd}, {1'b1, 32'h0})
    apb(1'b0, PTF_OFF_STATUS, 32'h0);
    `CHK(rd, 32'h00020001)
    summarize();
  end
endmodule : tb_ptf_top
